// ==== rtl/seeci_map.vh ====
// Constants for the serial EEPROM client interface
`ifndef SEECI_MAP_VH
`define SEECI_MAP_VH
`define SEECI_CTRL_CODE     4'hA
`define SEECI_CODE_MSB      7
`define SEECI_CODE_LSB      4
`define SEECI_BLK_MSB       2
`define SEECI_BLK_LSB       1
`define SEECI_RW_BIT        0
`define SEECI_ADDR_W        10
`define SEECI_MEM_DEPTH     1024
`define SEECI_PAGE_SIZE     16
`define SEECI_PROT_BIT      9
`define SEECI_BIT_LAST      4'h7
`define SEECI_BIT_ACK       4'h8
`define SEECI_BIT_START     4'hF
`define SEECI_FIFO_WIDTH    18
`define SEECI_FIFO_DEPTH    8
`define SEECI_FIFO_AW       3
`define SEECI_TWC_MS        5
`define SEECI_CLK_MHZ       200
`define SEECI_TWC_CYCLES    (`SEECI_TWC_MS * 1000 * `SEECI_CLK_MHZ)
`endif

// ==== rtl/seeci_fifo.v ====
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module seeci_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             core_clk,
    input  wire             sys_rst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output reg  [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] store [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;

    assign in_ready  = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @* begin
        out_data = store[rd_ptr];
    end

    always @(posedge core_clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
        if (sys_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push & ~pop) begin
                count <= count + 1'b1;
            end else if (pop & ~push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/seeci_client.v ====
// Two-wire serial EEPROM client: bus front end, page buffer and array
//
// Overview of operation
// RULE1: Write-protect high blocks programming of upper half
// RULE2: Unused address pins never affect addressing
// RULE3: Host changes data only while clock low
// RULE4: Data fall with clock high is Start
// RULE5: Data rise with clock high is Stop
// RULE6: Host brackets operations with Start and Stop
// RULE7: Bus idle while both lines high
// RULE8: One clock pulse per bit, sampled high
// RULE9: Receiver pulls data low on ninth pulse
// RULE10: No acknowledge at all while programming
// RULE11: Host no-acknowledge ends read, line released
// RULE12: Control code must match, next bit ignored
// RULE13: Block bits become address top two bits
// RULE14: Lowest control bit selects read or write
// RULE15: Matching control byte is acknowledged, mode chosen
// RULE16: Write word address loads pointer, acknowledged
// RULE17: Single data byte acknowledged and stored
// RULE18: Programming starts only on Stop after data
// RULE19: Up to sixteen bytes buffered, committed at Stop
// RULE20: Only low four pointer bits increment
// RULE21: Page overrun wraps to page start
// RULE22: Write polling acknowledged only when cycle done
// RULE23: Pointer keeps last address plus one
// RULE24: Host acknowledge fetches next sequential byte
// RULE25: Wrong control code ignored until next Start
// RULE26: Protected buffered bytes dropped during programming
// RULE27: Busy lasts full write interval
`timescale 1ns/10ps
`default_nettype none
`include "seeci_map.vh"
module seeci_client #(
    parameter TWC_CYCLES = `SEECI_TWC_CYCLES
) (
    input  wire core_clk,
    input  wire sys_rst,
    input  wire scl_in,
    input  wire sda_in,
    output wire sda_out,
    output reg  sda_oe,
    input  wire write_protect,
    input  wire unused_address_pin_0,
    input  wire unused_address_pin_1,
    input  wire unused_address_pin_2,
    output reg  bus_idle,
    output reg  write_busy
);
    localparam [5:0] S_IDLE = 6'h01;
    localparam [5:0] S_CTRL = 6'h02;
    localparam [5:0] S_ADDR = 6'h04;
    localparam [5:0] S_DATA = 6'h08;
    localparam [5:0] S_READ = 6'h10;
    localparam [5:0] S_SKIP = 6'h20;
    localparam [3:0] C_IDLE = 4'h1;
    localparam [3:0] C_DRAIN = 4'h2;
    localparam [3:0] C_PROG = 4'h4;
    localparam [3:0] C_WAIT = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and bus conditions
    reg  [1:0] scl_sync;
    reg  [1:0] sda_sync;
    reg  [1:0] wp_sync;
    reg        scl_prev;
    reg        sda_prev;
    wire       scl_s = scl_sync[1];
    wire       sda_s = sda_sync[1];
    wire       wp_s  = wp_sync[1];
    wire       scl_rise = scl_s & ~scl_prev;
    wire       scl_fall = ~scl_s & scl_prev;
    wire       start_cond = scl_s & scl_prev & sda_prev & ~sda_s; // RULE4
    wire       stop_cond  = scl_s & scl_prev & ~sda_prev & sda_s; // RULE5

    // Address pins left unread; addressing ignores them // RULE2

    always @(posedge core_clk) begin
        if (sys_rst) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            wp_sync  <= 2'h0;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            bus_idle <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            wp_sync  <= {wp_sync[0], write_protect};
            scl_prev <= scl_s;
            sda_prev <= sda_s;
            bus_idle <= scl_s & sda_s; // RULE7
        end
    end

    assign sda_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // Helper decodes
    function is_ctrl_match;
        input [7:0] b;
        begin
            is_ctrl_match = (b[`SEECI_CODE_MSB:`SEECI_CODE_LSB] == `SEECI_CTRL_CODE);
        end
    endfunction

    function is_protected;
        input [`SEECI_ADDR_W-1:0] a;
        input                     wp;
        begin
            is_protected = wp & a[`SEECI_PROT_BIT];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Array with registered read
    reg  [7:0] mem [0:`SEECI_MEM_DEPTH-1];
    reg  [7:0] rd_data;
    reg  [`SEECI_ADDR_W-1:0] ptr;
    reg        mem_we;
    reg  [`SEECI_ADDR_W-1:0] mem_wa;
    reg  [7:0] mem_wd;

    always @(posedge core_clk) begin
        rd_data <= mem[ptr];
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Received-byte FIFO
    wire [17:0] fifo_out;
    wire        fifo_in_ready;
    wire        fifo_out_valid;
    reg         fifo_push;
    reg  [17:0] fifo_in;
    reg  [3:0]  cstate;
    wire        drain_ready = (cstate == C_IDLE) | (cstate == C_DRAIN);

    seeci_fifo #(
        .WIDTH (`SEECI_FIFO_WIDTH),
        .DEPTH (`SEECI_FIFO_DEPTH),
        .AW    (`SEECI_FIFO_AW)
    ) u_fifo (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_data   (fifo_in),
        .in_valid  (fifo_push),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (drain_ready)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus protocol state machine
    reg  [5:0] state;
    reg  [3:0] bit_cnt;
    reg  [7:0] rx;
    reg  [7:0] tx;
    reg        host_ack;
    reg        first_rd;
    reg        data_seen;
    reg        page_clear;
    reg        commit_req;
    wire [7:0] rx_byte = {rx[6:0], sda_s};

    always @(posedge core_clk) begin
        if (sys_rst) begin
            state      <= S_IDLE;
            bit_cnt    <= 4'h0;
            rx         <= 8'h00;
            tx         <= 8'hFF;
            ptr        <= {`SEECI_ADDR_W{1'b0}};
            sda_oe     <= 1'b0;
            host_ack   <= 1'b0;
            first_rd   <= 1'b0;
            data_seen  <= 1'b0;
            page_clear <= 1'b0;
            commit_req <= 1'b0;
            fifo_push  <= 1'b0;
            fifo_in    <= 18'h00000;
        end else begin
            fifo_push  <= 1'b0;
            page_clear <= 1'b0;
            commit_req <= 1'b0;
            if (start_cond) begin
                state   <= S_CTRL; // RULE4
                bit_cnt <= `SEECI_BIT_START;
                sda_oe  <= 1'b0;
            end else if (stop_cond) begin
                state   <= S_IDLE; // RULE5
                sda_oe  <= 1'b0;
                commit_req <= (state == S_DATA) & data_seen; // RULE18
                data_seen  <= 1'b0;
            end else if (scl_rise) begin
                if (bit_cnt < `SEECI_BIT_ACK) begin
                    rx <= rx_byte; // RULE8
                end else if (state == S_READ) begin
                    host_ack <= ~sda_s; // RULE11
                end
            end else if (scl_fall) begin
                case (state)
                    S_CTRL, S_ADDR, S_DATA: begin
                        if (bit_cnt == `SEECI_BIT_LAST) begin
                            bit_cnt <= `SEECI_BIT_ACK;
                            if (state == S_CTRL) begin
                                if (is_ctrl_match(rx) & ~write_busy) begin // RULE12 RULE10 RULE22
                                    sda_oe <= 1'b1; // RULE15 RULE9
                                    if (rx[`SEECI_RW_BIT]) begin // RULE14
                                        state    <= S_READ;
                                        first_rd <= 1'b1;
                                        ptr[9:8] <= rx[`SEECI_BLK_MSB:`SEECI_BLK_LSB]; // RULE13
                                    end else begin
                                        state    <= S_ADDR;
                                        tx[1:0]  <= rx[`SEECI_BLK_MSB:`SEECI_BLK_LSB];
                                    end
                                end else begin
                                    state <= S_SKIP; // RULE25
                                end
                            end else if (state == S_ADDR) begin
                                ptr        <= {tx[1:0], rx}; // RULE16 RULE13
                                sda_oe     <= 1'b1;
                                state      <= S_DATA;
                                page_clear <= 1'b1;
                            end else if (fifo_in_ready) begin
                                fifo_push <= 1'b1; // RULE17 RULE19
                                fifo_in   <= {ptr, rx};
                                ptr[3:0]  <= ptr[3:0] + 4'h1; // RULE20 RULE21
                                sda_oe    <= 1'b1;
                                data_seen <= 1'b1;
                            end else begin
                                state <= S_SKIP;
                            end
                        end else if (bit_cnt == `SEECI_BIT_ACK) begin
                            bit_cnt <= 4'h0;
                            sda_oe  <= 1'b0;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                    end
                    S_READ: begin
                        if (bit_cnt == `SEECI_BIT_ACK) begin
                            bit_cnt  <= 4'h0;
                            first_rd <= 1'b0;
                            if (first_rd | host_ack) begin
                                tx     <= rd_data; // RULE24 RULE23
                                sda_oe <= ~rd_data[7];
                                ptr    <= ptr + 1'b1;
                            end else begin
                                sda_oe <= 1'b0; // RULE11
                                state  <= S_SKIP;
                            end
                        end else if (bit_cnt == `SEECI_BIT_LAST) begin
                            bit_cnt <= `SEECI_BIT_ACK;
                            sda_oe  <= 1'b0;
                        end else begin
                            bit_cnt <= bit_cnt + 4'h1;
                            tx      <= {tx[6:0], 1'b1};
                            sda_oe  <= ~tx[6];
                        end
                    end
                    S_IDLE, S_SKIP: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        state  <= S_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Page buffer and self-timed programming
    reg  [7:0]  pbuf [0:`SEECI_PAGE_SIZE-1];
    reg  [15:0] pval;
    reg  [5:0]  pbase;
    reg  [3:0]  pidx;
    reg  [19:0] wait_cnt;
    wire [`SEECI_ADDR_W-1:0] prog_addr = {pbase, pidx};
    localparam integer TWC_LAST = TWC_CYCLES - 1;

    always @(posedge core_clk) begin
        if (fifo_out_valid & drain_ready) begin
            pbuf[fifo_out[11:8]] <= fifo_out[7:0]; // RULE20
        end
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            cstate     <= C_IDLE;
            pval       <= 16'h0000;
            pbase      <= 6'h00;
            pidx       <= 4'h0;
            wait_cnt   <= 20'h00000;
            write_busy <= 1'b0;
            mem_we     <= 1'b0;
            mem_wa     <= {`SEECI_ADDR_W{1'b0}};
            mem_wd     <= 8'h00;
        end else begin
            mem_we <= 1'b0;
            if (page_clear) begin
                pval <= 16'h0000;
            end
            if (fifo_out_valid & drain_ready) begin
                pval[fifo_out[11:8]] <= 1'b1; // RULE19
                pbase <= fifo_out[17:12];
            end
            case (cstate)
                C_IDLE: begin
                    if (commit_req) begin
                        cstate     <= C_DRAIN; // RULE18
                        write_busy <= 1'b1; // RULE10
                    end
                end
                C_DRAIN: begin
                    if (~fifo_out_valid) begin
                        cstate <= C_PROG;
                        pidx   <= 4'h0;
                    end
                end
                C_PROG: begin
                    mem_we <= pval[pidx] & ~is_protected(prog_addr, wp_s); // RULE1 RULE26
                    mem_wa <= prog_addr;
                    mem_wd <= pbuf[pidx];
                    pidx   <= pidx + 4'h1;
                    if (pidx == 4'hF) begin
                        cstate   <= C_WAIT;
                        wait_cnt <= 20'h00000;
                        pval     <= 16'h0000;
                    end
                end
                C_WAIT: begin
                    wait_cnt <= wait_cnt + 20'h00001;
                    if (wait_cnt >= TWC_LAST[19:0]) begin
                        cstate     <= C_IDLE; // RULE27
                        write_busy <= 1'b0;
                    end
                end
                default: begin
                    cstate     <= C_IDLE;
                    write_busy <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== tb/seeci_client_properties.sv ====
// Port checker for the serial EEPROM client
`timescale 1ns/10ps
`default_nettype none
module seeci_client_props #(
    parameter TWC_CYCLES = 200
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic write_protect,
    input wire logic unused_address_pin_0,
    input wire logic unused_address_pin_1,
    input wire logic unused_address_pin_2,
    input wire logic bus_idle,
    input wire logic write_busy
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic       sda_q;
    logic [7:0] since_stop;
    int         busy_cnt;
    ////////////////////////////////////////////////////////////////////////////
    // Cycles since a stop on the pins, cycles spent busy
    always @(posedge core_clk) begin
        sda_q <= sda_in;
        if (sys_rst || (scl_in && sda_in && !sda_q))
            since_stop <= 8'h00;
        else if (since_stop != 8'hFF)
            since_stop <= since_stop + 8'h01;
        busy_cnt <= (sys_rst || !write_busy) ? 0 : busy_cnt + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_stop;
        scl_in && $rose(sda_in);
    endsequence
    sequence s_hold;
        sda_oe [*8];
    endsequence
    property p_stop_idle;
        s_stop |-> ##[2:5] bus_idle;
    endproperty
    property p_low_busy;
        !scl_in [*4] |-> !bus_idle;
    endproperty
    property p_oe_change;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    property p_ack_hold;
        $rose(scl_in) && sda_oe |=> s_hold;
    endproperty
    property p_drive_low;
        sda_out == 1'b0;
    endproperty
    property p_no_ack_busy;
        write_busy |-> !sda_oe;
    endproperty
    property p_busy_start;
        $rose(write_busy) |-> since_stop <= 8'h08;
    endproperty
    property p_busy_len;
        $fell(write_busy) |-> busy_cnt >= TWC_CYCLES && busy_cnt <= TWC_CYCLES + 64;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("idle late after stop");
    a_low_busy: assert property (p_low_busy) else $error("idle with clock low");
    a_oe_change: assert property (p_oe_change) else $error("data moved, clock high");
    a_ack_hold: assert property (p_ack_hold) else $error("low not held");
    a_drive_low: assert property (p_drive_low) else $error("data drive not low");
    a_no_ack_busy: assert property (p_no_ack_busy) else $error("drive while busy");
    a_busy_start: assert property (p_busy_start) else $error("busy without stop");
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule
bind seeci_client seeci_client_props #(.TWC_CYCLES(TWC_CYCLES)) i_seeci_client_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
    .unused_address_pin_0(unused_address_pin_0), .unused_address_pin_1(unused_address_pin_1),
    .unused_address_pin_2(unused_address_pin_2), .bus_idle(bus_idle), .write_busy(write_busy));
`default_nettype wire

// ==== tb/seeci_host.sv ====
// Bus host model driving the serial clock and pulling data low
`timescale 1ns/10ps
`default_nettype none
module seeci_host (
    input  wire logic core_clk,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic start_cond;
        wt(6);
        sda_pull = 1'b0;
        wt(7);
        scl = 1'b1;
        wt(12);
        sda_pull = 1'b1;
        wt(12);
        scl = 1'b0;
    endtask
    task automatic stop_cond;
        wt(6);
        sda_pull = 1'b1;
        wt(7);
        scl = 1'b1;
        wt(12);
        sda_pull = 1'b0;
        wt(25);
    endtask
    task automatic xfer_bit(input logic b, output logic r);
        wt(6);
        sda_pull = ~b;
        wt(7);
        scl = 1'b1;
        wt(6);
        r = sda;
        wt(6);
        scl = 1'b0;
    endtask
    task automatic xfer_byte(input logic [7:0] d, input logic last, output logic [7:0] r,
                             output logic nine);
        for (int i = 7; i >= 0; i--)
            xfer_bit(d[i], r[i]);
        xfer_bit(last, nine);
    endtask
endmodule
`default_nettype wire

// ==== tb/seeci_client_tb_top.sv ====
// Self-checking bench for the serial EEPROM client
`timescale 1ns/10ps
`default_nettype none
module seeci_client_tb_top;
    localparam int TWC = 400;
    logic       core_clk;
    logic       sys_rst;
    logic       write_protect;
    logic [2:0] unused_pins;
    wire        scl;
    wire        sda_pull;
    wire        sda_oe;
    wire        sda_out;
    wire        bus_idle;
    wire        write_busy;
    wire        sda = ~(sda_pull | sda_oe);
    int         failures;
    int         checked;
    int         seed;
    int         cycles = 0;
    logic [7:0] mem_exp [0:1023];
    logic       known [0:1023];
    logic [9:0] a;
    seeci_client #(.TWC_CYCLES(TWC)) i_seeci_client (
        .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
        .unused_address_pin_0(unused_pins[0]), .unused_address_pin_1(unused_pins[1]),
        .unused_address_pin_2(unused_pins[2]), .bus_idle(bus_idle), .write_busy(write_busy));
    seeci_host i_seeci_host (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            failures = failures + 1;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [7:0] ctrl(input logic [1:0] blk, input logic rd);
        return {4'hA, 1'($random(seed)), blk, rd};
    endfunction
    task automatic send(input logic [7:0] d, input logic nack);
        logic [7:0] r;
        logic       n;
        unused_pins = 3'($random(seed));
        i_seeci_host.xfer_byte(d, 1'b1, r, n);
        check({7'h0, n}, {7'h0, nack});
    endtask
    task automatic poll;
        logic       ack;
        logic [7:0] r;
        int         k;
        k = 0;
        check({7'h0, write_busy}, 8'h01);
        do begin
            i_seeci_host.start_cond();
            i_seeci_host.xfer_byte(ctrl(2'($random(seed)), 1'b0), 1'b1, r, ack);
            if (k == 0)
                check({7'h0, ack}, 8'h01);
            i_seeci_host.stop_cond();
            k++;
        end while (ack && k < 20);
        check({7'h0, ack}, 8'h00);
    endtask
    task automatic page_write(input logic [9:0] p, input int n, input logic wp);
        logic [7:0] d;
        write_protect = wp;
        i_seeci_host.start_cond();
        send(ctrl(p[9:8], 1'b0), 1'b0);
        send(p[7:0], 1'b0);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            send(d, 1'b0);
            if (!(wp && p[9])) begin
                mem_exp[p] = d;
                known[p] = 1'b1;
            end
            p[3:0] = p[3:0] + 4'h1;
        end
        i_seeci_host.stop_cond();
        poll();
    endtask
    task automatic seq_read(input logic [9:0] p, input int n);
        logic [7:0] r;
        logic       ack;
        i_seeci_host.start_cond();
        send(ctrl(p[9:8], 1'b0), 1'b0);
        send(p[7:0], 1'b0);
        i_seeci_host.start_cond();
        send(ctrl(p[9:8], 1'b1), 1'b0);
        for (int i = 0; i < n; i++) begin
            i_seeci_host.xfer_byte(8'hFF, i == n - 1, r, ack);
            if (known[p])
                check(r, mem_exp[p]);
            p = p + 10'h001;
        end
        i_seeci_host.stop_cond();
        check({7'h0, write_busy}, 8'h00);
        i_seeci_host.start_cond();
        send(ctrl(p[9:8], 1'b1), 1'b0);
        i_seeci_host.xfer_byte(8'hFF, 1'b1, r, ack);
        if (known[p])
            check(r, mem_exp[p]);
        check({7'h0, ack}, 8'h01);
        i_seeci_host.stop_cond();
    endtask
    task automatic bad_code;
        logic [3:0] code;
        code = 4'($random(seed));
        if (code == 4'hA)
            code = 4'h5;
        i_seeci_host.start_cond();
        send({code, 4'($random(seed))}, 1'b1);
        send(8'h00, 1'b1);
        i_seeci_host.stop_cond();
        check({7'h0, write_busy}, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hBA67DFA8;
        sys_rst = 1'b1;
        write_protect = 1'b0;
        unused_pins = 3'h0;
        failures = 0;
        checked = 0;
        for (int i = 0; i < 1024; i++)
            known[i] = 1'b0;
        repeat (16) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check({5'h0, sda_oe, bus_idle, write_busy}, 8'h02);
        for (int j = 0; j < 5; j++) begin
            a = 10'($random(seed));
            if (j == 3)
                a[9] = 1'b1;
            if (j == 3)
                page_write(a, 16, 1'b0);
            page_write(a, (j == 0) ? 1 : (j == 1) ? 16 : (j == 2) ? 20 : 1 + ($unsigned($random(seed)) % 20),
                       (j == 3) ? 1'b1 : 1'($random(seed)));
            seq_read({a[9:4], 4'h0}, 15);
            bad_code();
        end
        finish_test();
    end
endmodule
`default_nettype wire
